// *** verilog/pdcfg_top.sv ***
// Master-page sleep, sleep-mask, performance and input-coupling configuration bank
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Buffer field 00 keeps its channel buffer on, 11 turns that buffer off.
// - Mask-choice bit 5 of sleep control selects mask one (0) or two (1).
// - Mask one lives at 20h/21h, mask two at 23h/24h.
// - Chip-wide sleep bit 1 puts the device into global sleep; the code takes the bit only while ignore-sleep-pin is already set.
// - Ignore-sleep-pin 1 disregards the sleep pin; 0 lets the pin control.
// - Performance setting bits 1:0 at 39h[7:6], bit 2 at 3Ah[6], bit 3 at 56h.
// - Register sleep enable 55h bit 4 applies the selected mask.
// - Core field 0Fh stops channel B, F0h channel A, FFh both.
// - Coupling bit 0 set switches the input bias for dc coupling.
module pdcfg_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] page_sel,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic sleep_pin,
    output logic global_sleep,
    output logic converter_sleep_a,
    output logic converter_sleep_b,
    output logic buffer_sleep_a,
    output logic buffer_sleep_b,
    output logic [3:0] performance_setting,
    output logic input_dc_bias_enable
);
    import pdcfg_pkg::*;

    // Stored register fields; unused bit positions have no storage at all
    logic [7:0] m1_conv_r;
    logic [1:0] m1_buf_a_r, m1_buf_b_r;
    logic [7:0] m2_conv_r;
    logic [1:0] m2_buf_a_r, m2_buf_b_r;
    logic chip_wide_sleep_r, ignore_sleep_pin_r, sleep_mask_choice_r, register_sleep_enable_r;
    logic [3:0] perf_r;
    logic dc_bias_r;
    logic global_sleep_r;
    logic [7:0] rdata_r;

    // ****************************************
    // Access decode
    // ****************************************
    // Accesses outside the master page are ignored and read zero
    wire logic page_ok = (page_sel == PDCFG_MASTER_PAGE);
    wire logic wr_hit = wr_en & page_ok;
    wire logic we_m1_conv = wr_hit & (addr == PDCFG_OFS_M1_CONV);
    wire logic we_m1_buf = wr_hit & (addr == PDCFG_OFS_M1_BUF);
    wire logic we_m2_conv = wr_hit & (addr == PDCFG_OFS_M2_CONV);
    wire logic we_m2_buf = wr_hit & (addr == PDCFG_OFS_M2_BUF);
    wire logic we_ctrl = wr_hit & (addr == PDCFG_OFS_SLEEP_CTRL);
    wire logic we_perf_lo = wr_hit & (addr == PDCFG_OFS_PERF_LOW);
    wire logic we_perf_mid = wr_hit & (addr == PDCFG_OFS_PERF_MID);
    wire logic we_perf_hi = wr_hit & (addr == PDCFG_OFS_PERF_HIGH);
    wire logic we_coupling = wr_hit & (addr == PDCFG_OFS_COUPLING);
    wire logic we_reg_sleep = wr_hit & (addr == PDCFG_OFS_REG_SLEEP);
    // Sleep bit guarded by the override value held before this write
    wire logic sleep_accept = we_ctrl & ignore_sleep_pin_r;

    // ****************************************
    // Mask registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            m1_conv_r <= PDCFG_RST_BYTE;
            m2_conv_r <= PDCFG_RST_BYTE;
        end else begin
            if (we_m1_conv) m1_conv_r <= wdata;
            if (we_m2_conv) m2_conv_r <= wdata;
        end
    end

    // Buffer fields; the low nibble is dropped and stays zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {m1_buf_b_r, m1_buf_a_r} <= PDCFG_RST_NIBBLE;
            {m2_buf_b_r, m2_buf_a_r} <= PDCFG_RST_NIBBLE;
        end else begin
            if (we_m1_buf) {m1_buf_b_r, m1_buf_a_r} <= wdata[7:4];
            if (we_m2_buf) {m2_buf_b_r, m2_buf_a_r} <= wdata[7:4];
        end
    end

    // ****************************************
    // Sleep control, performance and coupling
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chip_wide_sleep_r <= PDCFG_RST_BIT;
            ignore_sleep_pin_r <= PDCFG_RST_BIT;
            sleep_mask_choice_r <= PDCFG_RST_BIT;
            register_sleep_enable_r <= PDCFG_RST_BIT;
            dc_bias_r <= PDCFG_RST_BIT;
        end else begin
            if (sleep_accept) chip_wide_sleep_r <= wdata[PDCFG_BIT_CHIP_SLEEP];
            if (we_ctrl) ignore_sleep_pin_r <= wdata[PDCFG_BIT_IGNORE_PIN];
            if (we_ctrl) sleep_mask_choice_r <= wdata[PDCFG_BIT_MASK_CHOICE];
            if (we_reg_sleep) register_sleep_enable_r <= wdata[PDCFG_BIT_REG_SLEEP_EN];
            if (we_coupling) dc_bias_r <= wdata[PDCFG_BIT_DC_BIAS];
        end
    end

    // Three partial writes; the setting is only coherent once all three have landed.
    // No staging register: the core sees each part at once, so a half-written
    // setting is briefly live. Keeping the three writes together is up to software.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            perf_r <= PDCFG_RST_NIBBLE;
        end else begin
            if (we_perf_lo) perf_r[1:0] <= wdata[PDCFG_LSB_PERF_LOW +: 2];
            if (we_perf_mid) perf_r[2] <= wdata[PDCFG_BIT_PERF_MID];
            if (we_perf_hi) perf_r[3] <= wdata[PDCFG_BIT_PERF_HIGH];
        end
    end

    // Pin only counts while the override is clear
    always_ff @(posedge sys_clk) begin
        if (srst) global_sleep_r <= PDCFG_RST_BIT;
        else global_sleep_r <= chip_wide_sleep_r | (~ignore_sleep_pin_r & sleep_pin);
    end

    // ****************************************
    // Read back
    // ****************************************
    // Write-only positions, including the top performance bit, read zero
    wire logic [7:0] rd_mux =
        !page_ok ? 8'h00 :
        (addr == PDCFG_OFS_M1_CONV) ? m1_conv_r :
        (addr == PDCFG_OFS_M1_BUF) ? {m1_buf_b_r, m1_buf_a_r, 4'h0} :
        (addr == PDCFG_OFS_M2_CONV) ? m2_conv_r :
        (addr == PDCFG_OFS_M2_BUF) ? {m2_buf_b_r, m2_buf_a_r, 4'h0} :
        (addr == PDCFG_OFS_SLEEP_CTRL) ? {chip_wide_sleep_r, ignore_sleep_pin_r, sleep_mask_choice_r, 5'h00} :
        (addr == PDCFG_OFS_PERF_LOW) ? {perf_r[1:0], 6'h00} :
        (addr == PDCFG_OFS_PERF_MID) ? {1'b0, perf_r[2], 6'h00} :
        (addr == PDCFG_OFS_COUPLING) ? {7'h00, dc_bias_r} :
        (addr == PDCFG_OFS_REG_SLEEP) ? {3'h0, register_sleep_enable_r, 4'h0} : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (srst) rdata_r <= PDCFG_RST_BYTE;
        else if (rd_en) rdata_r <= rd_mux;
    end

    // ****************************************
    // Mask selector
    // ****************************************
    // Selector registers its decode, so mask outputs trail a write by two edges
    pdcfg_mask_if mif ();
    assign mif.m1_conv = m1_conv_r;
    assign mif.m1_buf_a = m1_buf_a_r;
    assign mif.m1_buf_b = m1_buf_b_r;
    assign mif.m2_conv = m2_conv_r;
    assign mif.m2_buf_a = m2_buf_a_r;
    assign mif.m2_buf_b = m2_buf_b_r;
    assign mif.choice = sleep_mask_choice_r;
    assign mif.enable = register_sleep_enable_r;

    pdcfg_mask_sel u_mask_sel (
        .sys_clk(sys_clk),
        .srst(srst),
        .mif(mif.sel)
    );

    // Outputs
    assign rdata = rdata_r;
    assign global_sleep = global_sleep_r;
    assign converter_sleep_a = mif.conv_off_a;
    assign converter_sleep_b = mif.conv_off_b;
    assign buffer_sleep_a = mif.buf_off_a;
    assign buffer_sleep_b = mif.buf_off_b;
    assign performance_setting = perf_r;
    assign input_dc_bias_enable = dc_bias_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_sleep_locked: assert property (we_ctrl && !ignore_sleep_pin_r |=> $stable(chip_wide_sleep_r))
        else $error("sleep bit changed without override");
    a_sleep_taken: assert property (sleep_accept && wdata[7] |=> ##1 global_sleep)
        else $error("global sleep not entered");
    a_pin_ignored: assert property (ignore_sleep_pin_r && !chip_wide_sleep_r |=> !global_sleep)
        else $error("pin acted while ignored");
    a_pin_follows: assert property (!ignore_sleep_pin_r && sleep_pin |=> global_sleep)
        else $error("pin sleep not applied");
    a_perf_split: assert property (we_perf_lo ##1 we_perf_mid ##1 we_perf_hi
        |=> performance_setting == {$past(wdata[2]), $past(wdata[6], 2), $past(wdata[7:6], 3)})
        else $error("performance setting assembled wrongly");
    a_unused_zero: assert property (rd_en && addr == PDCFG_OFS_M1_BUF |=> rdata[3:0] == 4'h0)
        else $error("unused bits read nonzero");
    a_page_guard: assert property (wr_en && !page_ok |=> $stable(perf_r) && $stable(m1_conv_r) && $stable(dc_bias_r))
        else $error("write outside master page took effect");
    a_dc_bias: assert property (we_coupling |=> input_dc_bias_enable == $past(wdata[0]))
        else $error("coupling bit not stored");
    a_mask_apply: assert property (we_reg_sleep && wdata[4] && !sleep_mask_choice_r && m1_conv_r == 8'hf0
        && !we_ctrl && !we_m1_conv |=> ##1 converter_sleep_a && !converter_sleep_b)
        else $error("selected mask not applied");

    // Field storage and read-back checks
    a_choice_stored: assert property (we_ctrl |=> sleep_mask_choice_r == $past(wdata[PDCFG_BIT_MASK_CHOICE]))
        else $error("mask choice not stored");
    a_override_stored: assert property (we_ctrl |=> ignore_sleep_pin_r == $past(wdata[PDCFG_BIT_IGNORE_PIN]))
        else $error("override bit not stored");
    a_perf_top_bit: assert property (we_perf_hi |=> performance_setting[3] == $past(wdata[PDCFG_BIT_PERF_HIGH]))
        else $error("top performance bit not stored");
    a_page_read_zero: assert property (rd_en && !page_ok |=> rdata == 8'h00)
        else $error("read outside master page returned data");
    a_coupling_unused: assert property (rd_en && page_ok && addr == PDCFG_OFS_COUPLING |=> rdata[7:1] == 7'h00)
        else $error("unused coupling bits read nonzero");

    c_global_sleep: cover property (sleep_accept && wdata[7]);
    c_perf_full: cover property (we_perf_lo ##1 we_perf_mid ##1 we_perf_hi);
    c_blocked_sleep: cover property (we_ctrl && !ignore_sleep_pin_r && wdata[7]);
endmodule // pdcfg_top
`default_nettype wire

// *** common/pdcfg_pkg.sv ***
// Offsets, field positions and reset values of the sleep and performance configuration bank
package pdcfg_pkg;
    // ****************************************
    // Register offsets (master page)
    // ****************************************
    localparam logic [7:0] PDCFG_OFS_M1_CONV = 8'h20;
    localparam logic [7:0] PDCFG_OFS_M1_BUF = 8'h21;
    localparam logic [7:0] PDCFG_OFS_M2_CONV = 8'h23;
    localparam logic [7:0] PDCFG_OFS_M2_BUF = 8'h24;
    localparam logic [7:0] PDCFG_OFS_SLEEP_CTRL = 8'h26;
    localparam logic [7:0] PDCFG_OFS_PERF_LOW = 8'h39;
    localparam logic [7:0] PDCFG_OFS_PERF_MID = 8'h3a;
    localparam logic [7:0] PDCFG_OFS_COUPLING = 8'h4f;
    localparam logic [7:0] PDCFG_OFS_REG_SLEEP = 8'h55;
    localparam logic [7:0] PDCFG_OFS_PERF_HIGH = 8'h56;
    // Value of the page selector that opens this bank
    localparam logic [7:0] PDCFG_MASTER_PAGE = 8'h80;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PDCFG_BIT_CHIP_SLEEP = 7;
    localparam int PDCFG_BIT_IGNORE_PIN = 6;
    localparam int PDCFG_BIT_MASK_CHOICE = 5;
    localparam int PDCFG_BIT_REG_SLEEP_EN = 4;
    localparam int PDCFG_BIT_PERF_MID = 6;
    localparam int PDCFG_BIT_PERF_HIGH = 2;
    localparam int PDCFG_BIT_DC_BIAS = 0;
    localparam int PDCFG_LSB_PERF_LOW = 6;
    localparam int PDCFG_LSB_BUF_A = 4;
    localparam int PDCFG_LSB_BUF_B = 6;
    localparam int PDCFG_LSB_CONV_A = 4;
    localparam int PDCFG_LSB_CONV_B = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PDCFG_RST_BYTE = 8'h00;
    localparam logic [3:0] PDCFG_RST_NIBBLE = 4'h0;
    localparam logic PDCFG_RST_BIT = 1'b0;

    // Field counts as switched off only when every bit of it is set
    function automatic logic pdcfg_all_set(input logic [3:0] field, input int width);
        logic res;
        res = 1'b1;
        for (int i = 0; i < width; i++) begin
            res = res & field[i];
        end
        return res;
    endfunction
endpackage

// *** common/pdcfg_mask_if.sv ***
// Mask contents and decoded sleep results passed between the register bank and the mask selector
`timescale 1ns/10ps
`default_nettype none
interface pdcfg_mask_if;
    logic [7:0] m1_conv;
    logic [1:0] m1_buf_a;
    logic [1:0] m1_buf_b;
    logic [7:0] m2_conv;
    logic [1:0] m2_buf_a;
    logic [1:0] m2_buf_b;
    logic choice;
    logic enable;
    logic conv_off_a;
    logic conv_off_b;
    logic buf_off_a;
    logic buf_off_b;

    modport bank (output m1_conv, m1_buf_a, m1_buf_b, m2_conv, m2_buf_a, m2_buf_b, choice, enable,
                  input conv_off_a, conv_off_b, buf_off_a, buf_off_b);
    modport sel (input m1_conv, m1_buf_a, m1_buf_b, m2_conv, m2_buf_a, m2_buf_b, choice, enable,
                 output conv_off_a, conv_off_b, buf_off_a, buf_off_b);
endinterface
`default_nettype wire

// *** verilog/pdcfg_mask_sel.sv ***
// Selects the active sleep mask and decodes it into per-channel sleep controls
`timescale 1ns/10ps
`default_nettype none
module pdcfg_mask_sel (
    input wire logic sys_clk,
    input wire logic srst,
    pdcfg_mask_if.sel mif
);
    import pdcfg_pkg::*;

    // ****************************************
    // Mask selection
    // ****************************************
    // Choice bit picks mask one or mask two
    wire logic [7:0] conv_sel = mif.choice ? mif.m2_conv : mif.m1_conv;
    wire logic [1:0] buf_a_sel = mif.choice ? mif.m2_buf_a : mif.m1_buf_a;
    wire logic [1:0] buf_b_sel = mif.choice ? mif.m2_buf_b : mif.m1_buf_b;
    // Only all-ones fields switch off; the forbidden codes 01 and 10 leave the part running
    wire logic conv_a_nxt = mif.enable & pdcfg_all_set(conv_sel[PDCFG_LSB_CONV_A +: 4], 4);
    wire logic conv_b_nxt = mif.enable & pdcfg_all_set(conv_sel[PDCFG_LSB_CONV_B +: 4], 4);
    wire logic buf_a_nxt = mif.enable & pdcfg_all_set({2'b00, buf_a_sel}, 2);
    wire logic buf_b_nxt = mif.enable & pdcfg_all_set({2'b00, buf_b_sel}, 2);

    // Registered so the analog controls never glitch while the selector flips
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mif.conv_off_a <= 1'b0;
            mif.conv_off_b <= 1'b0;
            mif.buf_off_a <= 1'b0;
            mif.buf_off_b <= 1'b0;
        end else begin
            mif.conv_off_a <= conv_a_nxt;
            mif.conv_off_b <= conv_b_nxt;
            mif.buf_off_a <= buf_a_nxt;
            mif.buf_off_b <= buf_b_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_buffer_full_off: assert property (mif.enable && !mif.choice && mif.m1_buf_a == 2'b11 |=> mif.buf_off_a)
        else $error("buffer A not off with mask one at 11");
    a_buffer_running: assert property (buf_a_sel == 2'b00 |=> !mif.buf_off_a)
        else $error("buffer A off with field 00");
    a_mask_two_pick: assert property (mif.enable && mif.choice && mif.m2_conv == 8'h0f && mif.m1_conv == 8'hf0
        |=> mif.conv_off_b && !mif.conv_off_a)
        else $error("mask two not applied");
    a_core_codes: assert property (mif.enable && conv_sel == 8'hff |=> mif.conv_off_a && mif.conv_off_b)
        else $error("code ff did not stop both cores");
    a_enable_gate: assert property (!mif.enable |=> !mif.conv_off_a && !mif.conv_off_b && !mif.buf_off_a)
        else $error("sleep applied while mask disabled");

    c_both_cores: cover property (mif.conv_off_a && mif.conv_off_b);
    c_mask_two: cover property (mif.choice && mif.enable ##1 mif.buf_off_b);
endmodule // pdcfg_mask_sel
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the sleep, sleep-mask, performance and input-coupling register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pdcfg_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] page_sel = PDCFG_MASTER_PAGE;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic sleep_pin = 1'b0;
    logic [7:0] rdata;
    logic global_sleep, converter_sleep_a, converter_sleep_b, buffer_sleep_a, buffer_sleep_b;
    logic [3:0] performance_setting;
    logic input_dc_bias_enable;
    logic [3:0] slp;
    int n_fail = 0;
    int num_checks = 0;

    // Decoded sleep outputs gathered as A core, B core, A buffer, B buffer
    assign slp = {converter_sleep_a, converter_sleep_b, buffer_sleep_a, buffer_sleep_b};

    pdcfg_top i_pdcfg_top (.sys_clk(sys_clk), .srst(srst), .page_sel(page_sel), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata), .sleep_pin(sleep_pin), .global_sleep(global_sleep),
        .converter_sleep_a(converter_sleep_a), .converter_sleep_b(converter_sleep_b),
        .buffer_sleep_a(buffer_sleep_a), .buffer_sleep_b(buffer_sleep_b),
        .performance_setting(performance_setting), .input_dc_bias_enable(input_dc_bias_enable));

    // Half period of the 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs move on the falling edge so the rising edge always sees settled values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge sys_clk);
        wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge sys_clk);
        rd_en = 1'b0;
        check("rdata", rdata, exp);
    endtask

    // Decoded outputs trail a write by two edges; three leaves margin
    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        logic [7:0] ofs [10];
        ofs = '{PDCFG_OFS_M1_CONV, PDCFG_OFS_M1_BUF, PDCFG_OFS_M2_CONV, PDCFG_OFS_M2_BUF, PDCFG_OFS_SLEEP_CTRL,
                PDCFG_OFS_PERF_LOW, PDCFG_OFS_PERF_MID, PDCFG_OFS_COUPLING, PDCFG_OFS_REG_SLEEP, PDCFG_OFS_PERF_HIGH};
        foreach (ofs[i]) rd_chk(ofs[i], PDCFG_RST_BYTE);
        check("sleep outputs", {4'h0, slp}, 8'h00);
        check("global_sleep", {7'h0, global_sleep}, 8'h00);
    endtask

    task automatic t_chip_sleep();
        wr(PDCFG_OFS_SLEEP_CTRL, 8'h80);
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h00);
        rd_chk(PDCFG_OFS_SLEEP_CTRL, 8'h00);
        // Override and sleep in one write: the sleep bit must still be refused
        wr(PDCFG_OFS_SLEEP_CTRL, 8'hc0);
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h00);
        rd_chk(PDCFG_OFS_SLEEP_CTRL, 8'h40);
        wr(PDCFG_OFS_SLEEP_CTRL, 8'hdf);
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h01);
        rd_chk(PDCFG_OFS_SLEEP_CTRL, 8'hc0);
        sleep_pin = 1'b1;
        wr(PDCFG_OFS_SLEEP_CTRL, 8'h40);
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h00);
        wr(PDCFG_OFS_SLEEP_CTRL, 8'h00);
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h01);
        sleep_pin = 1'b0;
        settle();
        check("global_sleep", {7'h0, global_sleep}, 8'h00);
    endtask

    task automatic t_masks();
        wr(PDCFG_OFS_M1_CONV, 8'hf0);
        wr(PDCFG_OFS_M1_BUF, 8'h30);
        wr(PDCFG_OFS_M2_CONV, 8'h0f);
        wr(PDCFG_OFS_M2_BUF, 8'hcf);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h00);
        wr(PDCFG_OFS_REG_SLEEP, 8'hff);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h0a);
        rd_chk(PDCFG_OFS_M2_BUF, 8'hc0);
        rd_chk(PDCFG_OFS_REG_SLEEP, 8'h10);
        wr(PDCFG_OFS_SLEEP_CTRL, 8'h20);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h05);
        rd_chk(PDCFG_OFS_SLEEP_CTRL, 8'h20);
        wr(PDCFG_OFS_M2_CONV, 8'hff);
        wr(PDCFG_OFS_M2_BUF, 8'hf0);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h0f);
        // Forbidden buffer codes must not put a buffer to sleep
        wr(PDCFG_OFS_M2_BUF, 8'h90);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h0c);
        wr(PDCFG_OFS_REG_SLEEP, 8'h00);
        settle();
        check("sleep outputs", {4'h0, slp}, 8'h00);
    endtask

    task automatic t_performance();
        wr(PDCFG_OFS_PERF_LOW, 8'hff);
        wr(PDCFG_OFS_PERF_MID, 8'hff);
        wr(PDCFG_OFS_PERF_HIGH, 8'h04);
        settle();
        check("performance_setting", {4'h0, performance_setting}, 8'h0f);
        rd_chk(PDCFG_OFS_PERF_LOW, 8'hc0);
        rd_chk(PDCFG_OFS_PERF_MID, 8'h40);
        rd_chk(PDCFG_OFS_PERF_HIGH, 8'h00);
        wr(PDCFG_OFS_PERF_LOW, 8'h40);
        wr(PDCFG_OFS_PERF_MID, 8'h00);
        wr(PDCFG_OFS_PERF_HIGH, 8'hfb);
        settle();
        check("performance_setting", {4'h0, performance_setting}, 8'h01);
        // All three parts on consecutive edges, strobe held high throughout
        @(negedge sys_clk);
        wr_en = 1'b1;
        addr = PDCFG_OFS_PERF_LOW;
        wdata = 8'h80;
        @(negedge sys_clk);
        addr = PDCFG_OFS_PERF_MID;
        wdata = 8'h40;
        @(negedge sys_clk);
        addr = PDCFG_OFS_PERF_HIGH;
        wdata = 8'h00;
        @(negedge sys_clk);
        wr_en = 1'b0;
        settle();
        check("performance_setting", {4'h0, performance_setting}, 8'h06);
    endtask

    task automatic t_coupling_and_page();
        page_sel = 8'h0f;
        wr(PDCFG_OFS_COUPLING, 8'h01);
        settle();
        check("input_dc_bias_enable", {7'h0, input_dc_bias_enable}, 8'h00);
        page_sel = PDCFG_MASTER_PAGE;
        wr(PDCFG_OFS_COUPLING, 8'hff);
        settle();
        check("input_dc_bias_enable", {7'h0, input_dc_bias_enable}, 8'h01);
        page_sel = 8'h0f;
        rd_chk(PDCFG_OFS_COUPLING, 8'h00);
        page_sel = PDCFG_MASTER_PAGE;
        rd_chk(PDCFG_OFS_COUPLING, 8'h01);
        // Unmapped offset reads zero and swallows writes
        wr(8'h30, 8'hff);
        rd_chk(8'h30, 8'h00);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        t_reset_values();
        t_chip_sleep();
        t_masks();
        t_performance();
        t_coupling_and_page();
        stop_test();
    end

    // About 160 cycles of traffic; the limit leaves wide margin
    initial begin
        #(5000 * 50);
        n_fail++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
